/* rtl/sdpc_core.sv */
/*
 * Device-side pin and command interface of a four-bank 32-bit SDRAM, with a
 * small behavioural array per bank (one row image of 256 columns per bank).
 * Assumes inputs are synchronous to sys_clk; data pins are split in/out/enable.
 */
`timescale 1ns/1ns
module sdpc_core
	import sdpc_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic resetn, // synchronous reset, active low
	input wire sdpc_pins_t pins, // control, address, bank, masks
	input wire logic [DATA_W-1:0] dq_in, // data pins as seen
	output logic [DATA_W-1:0] dq_out, // read data driven
	output logic [LANES-1:0] dq_oe_n, // per-lane drive enable, low drives
	output sdpc_pw_t power_state, // current clock-gate state
	output logic [NBANK-1:0] bank_open, // banks holding an open row
	output logic [ADDR_W-1:0] mode_cfg // stored mode op-code
);

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	function automatic logic [3:0] cmd_code(input sdpc_cmd_t c);
		cmd_code = {c.cs_n, c.ras_n, c.cas_n, c.we_n};
		if (c.cs_n) begin
			cmd_code = CMD_NOP;
		end
	endfunction : cmd_code

	function automatic logic [COL_W-1:0] burst_len(input logic [ADDR_W-1:0] m);
		case (m[MODE_BL_LSB +: 3])
			3'h0: burst_len = 8'h01;
			3'h1: burst_len = 8'h02;
			3'h2: burst_len = 8'h04;
			3'h3: burst_len = 8'h08;
			3'h7: burst_len = 8'hFF;
			default: burst_len = 8'h01;
		endcase
	endfunction : burst_len

	logic clk_live;
	logic [3:0] cmd;
	logic [BANK_W-1:0] bank_idx;
	logic [DATA_W-1:0] mem [NBANK][MEM_DEPTH];
	logic [ROW_W-1:0] open_row [NBANK];
	logic burst_rd;
	logic burst_wr;
	logic burst_ap;
	logic [BANK_W-1:0] burst_bank;
	logic [COL_W-1:0] col;
	logic [COL_W-1:0] remain;
	logic [1:0] cas_lat;
	logic [2:0] rd_valid_pipe;
	logic [DATA_W-1:0] rd_pipe [3];
	logic [LANES-1:0] mask_pipe [MASK_LAT];
	logic [COL_W-1:0] next_col;

	// clock gated off or buffers disabled outside run
	assign clk_live = pins.clk_gate && (power_state == SDPC_PW_RUN);
	assign cmd = clk_live ? cmd_code(pins.cmd) : CMD_NOP;
	assign bank_idx = pins.bank_select;
	assign next_col = col + 8'h01;

	// ------------------------------------------------------------
	// power states
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			power_state <= SDPC_PW_RUN;
		end else begin
			case (power_state)
				SDPC_PW_RUN: begin
					if (!pins.clk_gate) begin
						if (burst_rd || burst_wr) begin
							power_state <= SDPC_PW_SUSPEND;
						end else if (pins.cmd.cs_n == 1'b0 && {pins.cmd.ras_n, pins.cmd.cas_n,
							pins.cmd.we_n} == 3'h1 && bank_open == '0) begin
							power_state <= SDPC_PW_SREF;
						end else begin
							power_state <= SDPC_PW_PDOWN;
						end
					end
				end
				SDPC_PW_PDOWN, SDPC_PW_SREF: begin
					if (pins.clk_gate) begin
						power_state <= SDPC_PW_RUN;
					end
				end
				SDPC_PW_SUSPEND: begin
					if (pins.clk_gate) begin
						power_state <= SDPC_PW_RUN;
					end
				end
				default: power_state <= SDPC_PW_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// mode configuration
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			mode_cfg <= MODE_RESET;
		end else if (cmd == CMD_LOAD_MODE && bank_open == '0) begin
			mode_cfg <= pins.addr;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cas_lat <= 2'h2;
		end else if (cmd == CMD_LOAD_MODE && bank_open == '0) begin
			cas_lat <= (pins.addr[MODE_CL_LSB +: 3] == 3'h1) ? 2'h1 :
				(pins.addr[MODE_CL_LSB +: 3] == 3'h3) ? 2'h3 : 2'h2;
		end
	end

	// ------------------------------------------------------------
	// banks and rows
	// ------------------------------------------------------------
	generate
		for (genvar b = 0; b < NBANK; b++) begin : g_bank
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					bank_open[b] <= 1'b0;
					open_row[b] <= '0;
				end else if (cmd == CMD_ACTIVE && bank_idx == b[BANK_W-1:0]) begin
					bank_open[b] <= 1'b1;
					open_row[b] <= pins.addr[ROW_W-1:0];
				end else if (cmd == CMD_PRECHARGE && (pins.addr[AP_BIT] || bank_idx == b[BANK_W-1:0])) begin
					bank_open[b] <= 1'b0;
				end else if (burst_ap && burst_bank == b[BANK_W-1:0] && clk_live && remain == 8'h01) begin
					bank_open[b] <= 1'b0;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// burst engine
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			burst_rd <= 1'b0;
			burst_wr <= 1'b0;
			burst_ap <= 1'b0;
			burst_bank <= '0;
			col <= '0;
			remain <= '0;
		end else if ((cmd == CMD_READ || cmd == CMD_WRITE) && bank_open[bank_idx]) begin
			burst_rd <= (cmd == CMD_READ);
			burst_wr <= (cmd == CMD_WRITE);
			burst_ap <= pins.addr[AP_BIT];
			burst_bank <= bank_idx;
			col <= pins.addr[COL_W-1:0];
			remain <= burst_len(mode_cfg);
		end else if (cmd == CMD_TERMINATE || cmd == CMD_PRECHARGE) begin
			burst_rd <= 1'b0;
			burst_wr <= 1'b0;
			burst_ap <= 1'b0;
		end else if ((burst_rd || burst_wr) && clk_live) begin
			col <= next_col;
			if (remain == 8'h01) begin
				burst_rd <= 1'b0;
				burst_wr <= 1'b0;
				burst_ap <= 1'b0;
			end
			if (remain != 8'hFF) begin
				remain <= remain - 8'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// write path, byte masked
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		for (int l = 0; l < LANES; l++) begin
			if (clk_live && cmd == CMD_WRITE && bank_open[bank_idx] && !pins.byte_mask_lanes[l]) begin
				mem[bank_idx][pins.addr[COL_W-1:0]][l*8 +: 8] <= dq_in[l*8 +: 8];
			end else if (clk_live && burst_wr && remain != 8'h01 && cmd != CMD_WRITE
				&& !pins.byte_mask_lanes[l]) begin
				mem[burst_bank][next_col][l*8 +: 8] <= dq_in[l*8 +: 8];
			end
		end
	end

	// ------------------------------------------------------------
	// read pipeline
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rd_valid_pipe <= '0;
			for (int i = 0; i < 3; i++) begin
				rd_pipe[i] <= '0;
			end
		end else if (power_state != SDPC_PW_SUSPEND && pins.clk_gate) begin
			rd_valid_pipe <= {rd_valid_pipe[1:0], 1'b0};
			rd_pipe[1] <= rd_pipe[0];
			rd_pipe[2] <= rd_pipe[1];
			if (cmd == CMD_READ && bank_open[bank_idx]) begin
				rd_valid_pipe[0] <= 1'b1;
				rd_pipe[0] <= mem[bank_idx][pins.addr[COL_W-1:0]];
			end else if (burst_rd && remain != 8'h01) begin
				rd_valid_pipe[0] <= 1'b1;
				rd_pipe[0] <= mem[burst_bank][next_col];
			end
		end
	end

	// mask sampled on edge n floats lane at edge n+2
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			for (int i = 0; i < MASK_LAT; i++) begin
				mask_pipe[i] <= '0;
			end
		end else if (pins.clk_gate) begin
			mask_pipe[0] <= pins.byte_mask_lanes;
			mask_pipe[1] <= mask_pipe[0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			dq_out <= '0;
			dq_oe_n <= '1;
		end else if (pins.clk_gate) begin
			dq_out <= rd_pipe[cas_lat - 2'h1];
			for (int l = 0; l < LANES; l++) begin
				dq_oe_n[l] <= !(rd_valid_pipe[cas_lat - 2'h1] && !mask_pipe[MASK_LAT-1][l]);
			end
		end
	end
endmodule : sdpc_core

/* inc/sdpc_pkg.sv */
/*
 * Package for the SDRAM pin and command interface: command encodings, address
 * field positions, geometry, the mask latency and the pin carrier structs.
 * Assumes one synchronous clock shared with the memory controller.
 */
// Overview of operation
// - every input is captured only on the rising edge of the system clock.
// - each rising edge with clock gate high advances the burst column counter and output data registers; the counter holds on the edge leaving clock suspend.
// - select and the three command strobes are active low.
// - clock gate low enters power-down, self refresh, active power-down or clock suspend.
// - clock gate is synchronous except while in power-down or self refresh.
// - input buffers are disabled during power-down and self refresh.
// - commands decode only with select sampled low; otherwise ignored.
// - a running burst continues with select high; byte masking still applies.
// - command comes from select and the three strobes on one edge.
// - mask high during write stops that byte being written.
// - mask high during read floats that output byte two cycles later.
// - mask lanes 0..3 govern data bytes 0..3 in order.
// - bank select picks the bank for activate, read, write, single precharge.
// - activate takes an 11-bit row; read/write an 8-bit column plus auto precharge.
// - precharge with address bit 10 high closes all banks, else the selected one.
// - load-mode takes the configuration op-code from the address inputs.
// - the 32 data lines are bidirectional.
package sdpc_pkg;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int ADDR_W = 11;
	localparam int ROW_W = 11;
	localparam int COL_W = 8;
	localparam int BANK_W = 2;
	localparam int NBANK = 4;
	localparam int AP_BIT = 10;
	localparam int MEM_DEPTH = 256;
	// cs, ras, cas, we
	localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_ACTIVE = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_TERMINATE = 4'h6;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam int MODE_BL_LSB = 0;
	localparam int MODE_CL_LSB = 4;
	localparam logic [ADDR_W-1:0] MODE_RESET = 11'h022;
	localparam int MASK_LAT = 2;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} sdpc_cmd_t;

	typedef struct packed {
		logic clk_gate;
		sdpc_cmd_t cmd;
		logic [BANK_W-1:0] bank_select;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] byte_mask_lanes;
	} sdpc_pins_t;

	typedef enum logic [1:0] {
		SDPC_PW_RUN,
		SDPC_PW_PDOWN,
		SDPC_PW_SREF,
		SDPC_PW_SUSPEND
	} sdpc_pw_t;
endpackage : sdpc_pkg

/* verification/sdpc_ctrl_model.sv */
/* Controller-side data wire model for sdpc_core.
   Assumes one sys_clk domain; bench sets drive and wdata. */
`timescale 1ns/1ns
module sdpc_ctrl_model
	import sdpc_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic drive, // controller drives data
	input wire logic [DATA_W-1:0] wdata, // write data
	input wire logic [DATA_W-1:0] dq_out, // device data
	input wire logic [LANES-1:0] dq_oe_n, // device lane enables
	output logic [DATA_W-1:0] dq_in // resolved wire
);
	// ---
	// wire resolution
	// ---
	logic [DATA_W-1:0] last = 32'h0;
	always_ff @(posedge sys_clk) begin
		last <= dq_in;
	end
	always_comb begin
		for (int l = 0; l < LANES; l++) begin
			if (drive) dq_in[8*l+:8] = wdata[8*l+:8];
			else if (!dq_oe_n[l]) dq_in[8*l+:8] = dq_out[8*l+:8];
			else dq_in[8*l+:8] = ~last[8*l+:8];
		end
	end
endmodule : sdpc_ctrl_model

/* verification/sdpc_core_assertions.sv */
/* Port checker for sdpc_core.
   Assumes bind onto sdpc_core, one clock domain. */
`timescale 1ns/1ns
module sdpc_core_assertions
	import sdpc_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic resetn, // reset
	input wire sdpc_pins_t pins, // pins
	input wire logic [DATA_W-1:0] dq_in, // data in
	input wire logic [DATA_W-1:0] dq_out, // read data
	input wire logic [LANES-1:0] dq_oe_n, // lane enables
	input wire sdpc_pw_t power_state, // power state
	input wire logic [NBANK-1:0] bank_open, // open banks
	input wire logic [ADDR_W-1:0] mode_cfg // mode
);
	// ---
	// checks
	// ---
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire live = pins.clk_gate && power_state == SDPC_PW_RUN;
	wire [3:0] cmd = pins.cmd;
	sequence rd_s;
		live && cmd == CMD_READ && bank_open[pins.bank_select] && mode_cfg[6:0] == 7'h22 && pins.byte_mask_lanes == 4'h0;
	endsequence
	sequence quiet_s;
		pins.cmd.cs_n && pins.clk_gate;
	endsequence
	read_latency_a: assert property (rd_s |-> ##3 dq_oe_n == 4'h0) else $error("read data late");
	burst_on_a: assert property (rd_s ##1 quiet_s [*3] |-> ##1 (dq_oe_n & ~$past(pins.byte_mask_lanes, 3)) == 4'h0)
		else $error("burst dropped");
	activate_opens_a: assert property (live && cmd == CMD_ACTIVE |=> bank_open[$past(pins.bank_select)])
		else $error("bank not opened");
	prech_all_a: assert property (live && cmd == CMD_PRECHARGE && pins.addr[AP_BIT] |=> bank_open == 4'h0)
		else $error("banks left open");
	prech_one_a: assert property (live && cmd == CMD_PRECHARGE && !pins.addr[AP_BIT] |=> !bank_open[$past(pins.bank_select)])
		else $error("bank left open");
	mode_load_a: assert property (live && cmd == CMD_LOAD_MODE && bank_open == 4'h0 |=> mode_cfg == $past(pins.addr))
		else $error("mode not loaded");
	deselect_a: assert property (pins.cmd.cs_n |=> $stable(mode_cfg)) else $error("deselected command taken");
	other_cmd_a: assert property (!pins.cmd.cs_n && cmd != CMD_LOAD_MODE |=> $stable(mode_cfg))
		else $error("mode changed");
	mask_float_a: assert property (live && pins.byte_mask_lanes != 4'h0 |-> ##3
		(dq_oe_n & $past(pins.byte_mask_lanes, 3)) == $past(pins.byte_mask_lanes, 3)) else $error("lane driven");
	pdown_a: assert property (power_state == SDPC_PW_RUN && !pins.clk_gate && bank_open == 4'h0 && cmd == CMD_NOP
		|=> power_state == SDPC_PW_PDOWN) else $error("no power-down");
	pdown_hold_a: assert property (power_state == SDPC_PW_PDOWN |=> $stable(bank_open) && $stable(mode_cfg))
		else $error("input taken in power-down");
endmodule : sdpc_core_assertions
bind sdpc_core sdpc_core_assertions u_sdpc_core_assertions (.sys_clk, .resetn, .pins, .dq_in, .dq_out, .dq_oe_n,
	.power_state, .bank_open, .mode_cfg);

/* verification/sdpc_core_bench.sv */
/* Self-checking bench for sdpc_core with the controller model.
   Assumes a 100 MHz clock and the reset mode configuration. */
`timescale 1ns/1ns
module sdpc_core_bench;
	import sdpc_pkg::*;
	// ---
	// harness
	// ---
	localparam sdpc_pins_t NOP_P = {1'b1, CMD_NOP, 2'h0, 11'h000, 4'h0};
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	sdpc_pins_t pins = NOP_P;
	logic drive = 1'b0;
	logic [DATA_W-1:0] wdata = 32'h0;
	logic [DATA_W-1:0] dq_in;
	logic [DATA_W-1:0] dq_out;
	logic [LANES-1:0] dq_oe_n;
	sdpc_pw_t power_state;
	logic [NBANK-1:0] bank_open;
	logic [ADDR_W-1:0] mode_cfg;
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	sdpc_core u_sdpc_core (.sys_clk, .resetn, .pins, .dq_in, .dq_out, .dq_oe_n, .power_state, .bank_open, .mode_cfg);
	sdpc_ctrl_model u_sdpc_ctrl_model (.sys_clk, .drive, .wdata, .dq_out, .dq_oe_n, .dq_in);
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic sdpc_pins_t mk(logic [3:0] c, logic [1:0] b, logic [10:0] a, logic [3:0] m);
		mk = {1'b1, c, b, a, m};
	endfunction : mk
	task automatic step(sdpc_pins_t p, logic d = 1'b0, logic [31:0] w = 32'h0);
		@(posedge sys_clk);
		pins <= p;
		drive <= d;
		wdata <= w;
	endtask : step
	task automatic check(string name, logic [31:0] exp, logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic t_mode;
		step(mk(4'h8, 2'h0, 11'h032, 4'h0));
		step(mk(CMD_LOAD_MODE, 2'h0, 11'h032, 4'h0));
		#1 check("mode_kept", 32'h022, {21'h0, mode_cfg});
		step(NOP_P);
		#1 check("mode", 32'h032, {21'h0, mode_cfg});
		step(mk(CMD_LOAD_MODE, 2'h0, 11'h022, 4'h0));
		step(NOP_P);
	endtask : t_mode
	task automatic t_banks;
		for (int b = 0; b < 4; b++) begin
			step(mk(CMD_ACTIVE, b[1:0], 11'h7FF, 4'h0));
			step(NOP_P);
			#1 check("open", (32'h2 << b) - 1, {28'h0, bank_open});
		end
	endtask : t_banks
	task automatic t_burst;
		logic [31:0] exp;
		logic [31:0] msk;
		int j;
		for (int i = 0; i < 4; i++) step(mk(i == 0 ? CMD_WRITE : 4'hF, 2'h2, 11'h008, 4'h0), 1'b1,
			32'hA0A0A0A0 + i * 32'h01010101);
		for (int i = 0; i < 4; i++) step(mk(i == 0 ? CMD_WRITE : 4'hF, 2'h2, 11'h008, i == 0 ? 4'h2 : 4'hF), 1'b1,
			32'hBBBBBBBB);
		step(mk(CMD_READ, 2'h2, 11'h008, 4'h0));
		for (int k = 0; k < 7; k++) begin
			step(mk(4'hF, 2'h0, 11'h000, k == 0 ? 4'h8 : 4'h0));
			#1;
			j = k - 2;
			exp = (j == 0) ? 32'hBBBBA0BB : 32'hA0A0A0A0 + j * 32'h01010101;
			msk = (j == 1) ? 32'h00FFFFFF : 32'hFFFFFFFF;
			if (k == 6) check("oe_idle", 32'hF, {28'h0, dq_oe_n});
			else if (k >= 2) begin
				check("rd_data", exp & msk, dq_out & msk);
				check("rd_oe", (j == 1) ? 32'h8 : 32'h0, {28'h0, dq_oe_n});
			end
		end
	endtask : t_burst
	task automatic t_close;
		step(mk(CMD_PRECHARGE, 2'h2, 11'h000, 4'h0));
		step(NOP_P);
		#1 check("prech_one", 32'hB, {28'h0, bank_open});
		step(mk(CMD_READ, 2'h2, 11'h008, 4'h0));
		repeat (3) step(NOP_P);
		#1 check("closed_rd", 32'hF, {28'h0, dq_oe_n});
		step(mk(CMD_PRECHARGE, 2'h0, 11'h400, 4'h0));
		step(NOP_P);
		#1 check("prech_all", 32'h0, {28'h0, bank_open});
	endtask : t_close
	task automatic t_power;
		sdpc_pins_t p;
		p = NOP_P;
		p.clk_gate = 1'b0;
		step(p);
		step(p);
		#1 check("pdown", 32'(SDPC_PW_PDOWN), {30'h0, power_state});
		step(NOP_P);
		for (int i = 0; i < 4 && power_state !== SDPC_PW_RUN; i++) @(posedge sys_clk);
		#1 check("wake", 32'(SDPC_PW_RUN), {30'h0, power_state});
	endtask : t_power
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 check("rst_oe", 32'hF, {28'h0, dq_oe_n});
		check("rst_mode", 32'h022, {21'h0, mode_cfg});
		@(posedge sys_clk);
		resetn <= 1'b1;
		t_mode();
		t_banks();
		t_burst();
		t_close();
		t_power();
		report_and_stop();
	end
endmodule : sdpc_core_bench
